// file: i2c_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_master #(
    parameter int unsigned PHASE_DIV = i2c_pkg::PHASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // command: one pulse while idle
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [i2c_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [i2c_pkg::BYTE_W-1:0] cmd_reg,
    input wire logic [i2c_pkg::LEN_W-1:0] cmd_len,
    // write data, taken when wr_ready pulses
    input wire logic [i2c_pkg::BYTE_W-1:0] wr_data,
    output logic wr_ready,
    output logic [i2c_pkg::BYTE_W-1:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic done,
    output logic addr_ack,
    output logic nack_err,
    // open-drain pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    logic [1:0] sda_sync_q;
    logic [1:0] scl_sync_q;
    logic tick;
    i2c_pkg::state_t st_q, st_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [i2c_pkg::BYTE_W-1:0] sh_q, sh_d;
    logic [i2c_pkg::LEN_W-1:0] left_q, left_d;
    logic rd_q, rd_d;
    logic [i2c_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [i2c_pkg::BYTE_W-1:0] reg_q, reg_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic wr_ready_d, rd_valid_d, done_d, addr_ack_d, nack_err_d;
    logic [i2c_pkg::BYTE_W-1:0] rd_data_d;
    logic ack_sample;
    logic last_bit;

    i2c_phase_tick #(.DIV(PHASE_DIV)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .run(st_q != i2c_pkg::ST_IDLE),
        .tick(tick)
    );

    // scl_sync kept for observation only; stretching is not honoured
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_sync_q <= {scl_sync_q[0], scl_i};
        end
    end

    assign ack_sample = sda_sync_q[1];
    assign last_bit = (bit_q == i2c_pkg::ACK_BIT_IDX);

    // each bit is four phases: 0 set sda, 1 scl up, 2 sample sda into the shifter (the ack bit is read at 3 instead), 3 scl down
    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        bit_d = bit_q;
        sh_d = sh_q;
        left_d = left_q;
        rd_d = rd_q;
        addr_d = addr_q;
        reg_d = reg_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        wr_ready_d = 1'b0;
        rd_valid_d = 1'b0;
        done_d = 1'b0;
        addr_ack_d = addr_ack;
        nack_err_d = nack_err;
        rd_data_d = rd_data;
        case (st_q)
            i2c_pkg::ST_IDLE: begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
                if (cmd_valid) begin
                    st_d = i2c_pkg::ST_START;
                    ph_d = 2'h0;
                    rd_d = cmd_read;
                    addr_d = cmd_addr;
                    reg_d = cmd_reg;
                    left_d = (cmd_len == '0) ? i2c_pkg::LEN_W'(1) : cmd_len;
                    addr_ack_d = 1'b0;
                    nack_err_d = 1'b0;
                end
            end
            i2c_pkg::ST_START, i2c_pkg::ST_RSTART: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            sda_low_d = 1'b0;
                        end
                        2'h1: begin
                            scl_low_d = 1'b0;
                        end
                        2'h2: begin
                            sda_low_d = 1'b1;
                        end
                        default: begin
                            scl_low_d = 1'b1;
                            bit_d = '0;
                            if (st_q == i2c_pkg::ST_START) begin
                                st_d = i2c_pkg::ST_ADDR;
                                sh_d = {addr_q, i2c_pkg::DIR_WRITE};
                            end else begin
                                st_d = i2c_pkg::ST_RADDR;
                                sh_d = {addr_q, i2c_pkg::DIR_READ};
                            end
                        end
                    endcase
                end
            end
            i2c_pkg::ST_STOP: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            sda_low_d = 1'b1;
                        end
                        2'h1: begin
                            scl_low_d = 1'b0;
                        end
                        2'h2: begin
                            sda_low_d = 1'b0;
                        end
                        default: begin
                            st_d = i2c_pkg::ST_IDLE;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            i2c_pkg::ST_ADDR, i2c_pkg::ST_REG,
            i2c_pkg::ST_WDATA, i2c_pkg::ST_RADDR, i2c_pkg::ST_RDATA: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            if (last_bit) begin
                                // release for slave ack, or drive our own
                                sda_low_d = (st_q == i2c_pkg::ST_RDATA) &&
                                    (left_q != i2c_pkg::LEN_W'(1));
                            end else if (st_q == i2c_pkg::ST_RDATA) begin
                                sda_low_d = 1'b0;
                            end else begin
                                sda_low_d = !sh_q[i2c_pkg::BYTE_W-1];
                            end
                        end
                        2'h1: begin
                            scl_low_d = 1'b0;
                        end
                        2'h2: begin
                            if (!last_bit) begin
                                sh_d = {sh_q[i2c_pkg::BYTE_W-2:0], ack_sample};
                            end
                        end
                        default: begin
                            scl_low_d = 1'b1;
                            bit_d = bit_q + 4'h1;
                            if (last_bit) begin
                                bit_d = '0;
                                case (st_q)
                                    i2c_pkg::ST_ADDR, i2c_pkg::ST_RADDR: begin
                                        addr_ack_d = !ack_sample;
                                    end
                                    default: begin
                                    end
                                endcase
                                if (st_q == i2c_pkg::ST_RDATA) begin
                                    rd_data_d = sh_q;
                                    rd_valid_d = 1'b1;
                                    left_d = left_q - 1'b1;
                                    if (left_q == i2c_pkg::LEN_W'(1)) begin
                                        st_d = i2c_pkg::ST_STOP;
                                    end
                                end else if (ack_sample) begin
                                    nack_err_d = 1'b1;
                                    st_d = i2c_pkg::ST_STOP;
                                end else begin
                                    case (st_q)
                                        i2c_pkg::ST_ADDR: begin
                                            st_d = i2c_pkg::ST_REG;
                                            sh_d = reg_q;
                                        end
                                        i2c_pkg::ST_REG: begin
                                            if (rd_q) begin
                                                st_d = i2c_pkg::ST_RSTART;
                                                sda_low_d = 1'b0;
                                            end else begin
                                                st_d = i2c_pkg::ST_WDATA;
                                                sh_d = wr_data;
                                                wr_ready_d = 1'b1;
                                            end
                                        end
                                        i2c_pkg::ST_WDATA: begin
                                            left_d = left_q - 1'b1;
                                            if (left_q == i2c_pkg::LEN_W'(1)) begin
                                                st_d = i2c_pkg::ST_STOP;
                                            end else begin
                                                sh_d = wr_data;
                                                wr_ready_d = 1'b1;
                                            end
                                        end
                                        default: begin
                                            st_d = i2c_pkg::ST_RDATA;
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                st_d = i2c_pkg::ST_IDLE;
            end
        endcase
    end

    // no arbitration, bus assumed ours while busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= i2c_pkg::ST_IDLE;
            ph_q <= 2'h0;
            bit_q <= '0;
            sh_q <= '0;
            left_q <= '0;
            rd_q <= 1'b0;
            addr_q <= '0;
            reg_q <= '0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            wr_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            done <= 1'b0;
            addr_ack <= 1'b0;
            nack_err <= 1'b0;
            busy <= 1'b0;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            left_q <= left_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            reg_q <= reg_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            wr_ready <= wr_ready_d;
            rd_valid <= rd_valid_d;
            rd_data <= rd_data_d;
            done <= done_d;
            addr_ack <= addr_ack_d;
            nack_err <= nack_err_d;
            busy <= (st_d != i2c_pkg::ST_IDLE);
        end
    end

    // open drain: output always low, enable pulls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe <= scl_low_d;
            sda_oe <= sda_low_d;
        end
    end
endmodule // i2c_bus_master
`default_nettype wire

// file: i2c_bus_master_sva.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_master_sva #(
    parameter int unsigned PHASE_DIV = i2c_pkg::PHASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic wr_ready,
    input wire logic busy,
    input wire logic done,
    input wire logic nack_err,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe
);
    // one bit's four-phase group, with margin, bounds start and stop
    localparam int PH = 4 * (PHASE_DIV + 1);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin value not low");
    a_idle_lines: assert property (!busy |-> !scl_oe && !sda_oe)
        else $error("line held while idle");
    a_cmd_taken: assert property (cmd_valid && !busy |=> busy)
        else $error("command not taken");
    a_start_clocks: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:PH] scl_oe)
        else $error("start not followed by clock low");
    a_stop_done: assert property ($fell(sda_oe) && !scl_oe |-> ##[0:PH] done)
        else $error("sda rose with scl high outside stop");
    // lower bound only; exact for the bench divider of 2
    a_scl_high: assert property ($fell(scl_oe) |=> !scl_oe [*3])
        else $error("scl high phase short");
    a_scl_low: assert property ($rose(scl_oe) |=> scl_oe [*3])
        else $error("scl low phase short");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_wr_in_txn: assert property (wr_ready |-> busy)
        else $error("write data taken while idle");
    a_nack_stop: assert property ($rose(nack_err) |-> ##[0:PH] done)
        else $error("no stop after nack");
endmodule // i2c_bus_master_sva
`default_nettype wire

// file: i2c_phase_tick.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_phase_tick #(
    parameter int unsigned DIV = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    logic [i2c_pkg::PHASE_W-1:0] cnt_q, cnt_d;
    logic tick_d;

    always_comb begin
        cnt_d = cnt_q + 1'b1;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q == i2c_pkg::PHASE_W'(DIV - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // i2c_phase_tick
`default_nettype wire

// file: i2c_pkg.sv
package i2c_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SCL_HZ = 380_000;
    // four phases per scl period
    localparam int unsigned PHASE_CYCLES = CLK_HZ / (SCL_HZ * 4);
    localparam int unsigned PHASE_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam int unsigned LEN_W = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_REG = 4'b0011,
        ST_WDATA = 4'b0100,
        ST_RSTART = 4'b0101,
        ST_RADDR = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_STOP = 4'b1000
    } state_t;
endpackage

// file: i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] nack_at,
    output logic pull
);
    logic [7:0] sh, tx, mack_log;
    logic [7:0] rx [0:15];
    logic rd, hit, live, jr;
    int bitn, nb, ri, tn;
    initial begin
        {pull, rd, hit, live, jr, sh, tx, mack_log} = '0;
        {bitn, nb, ri, tn} = '0;
    end
    always @(negedge sda) if (scl) begin
        {nb, tn} = '0;
        // the start's own scl fall brings this to zero
        bitn = -1;
        rd = 1'b0;
        pull = 1'b0;
        if (!live) ri = 0;
        live = 1'b1;
    end
    always @(posedge sda) if (scl) begin
        live = 1'b0;
        pull = 1'b0;
    end
    always @(posedge scl) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else if (rd) mack_log = {mack_log[6:0], sda};
    end
    // only ever pulls low; release leaves the pull-up in charge
    always @(negedge scl) begin
        bitn = bitn + 1;
        if (bitn == 8 && !rd) begin
            if (nb == 0) begin
                hit = (sh[7:1] == dev_addr);
                rd = hit & sh[0];
                jr = rd;
            end
            rx[ri] = sh;
            ri = ri + 1;
            pull = hit && (nb != nack_at);
            nb = nb + 1;
        end else if (bitn == 8) pull = 1'b0;
        else if (bitn == 9) begin
            bitn = 0;
            if (rd && (jr || !mack_log[0])) begin
                jr = 1'b0;
                tx = 8'hc3 ^ 8'(tn);
                tn = tn + 1;
                pull = !tx[7];
            end else pull = 1'b0;
        end else if (rd && !jr) pull = !tx[7 - bitn];
    end
endmodule // i2c_slave_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int unsigned PD = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [i2c_pkg::ADDR_W-1:0] cmd_addr = '0;
    logic [i2c_pkg::BYTE_W-1:0] cmd_reg = '0;
    logic [i2c_pkg::LEN_W-1:0] cmd_len = '0;
    logic [i2c_pkg::BYTE_W-1:0] wr_data = '0;
    logic [i2c_pkg::BYTE_W-1:0] rd_data;
    logic [7:0] nack_at = 8'hff;
    logic wr_ready, rd_valid, busy, done, addr_ack, nack_err, scl_o, scl_oe, sda_o, sda_oe, pull;
    // open drain: pull-up wins unless someone pulls low
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || pull);
    logic [7:0] got [0:15];
    int n_errors = 0;
    int compares = 0;
    int nwr, nrd;
    always #10 clk = ~clk;
    i2c_bus_master #(.PHASE_DIV(PD)) uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .busy(busy), .done(done), .addr_ack(addr_ack), .nack_err(nack_err), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    i2c_slave_model dev (.scl(scl_w), .sda(sda_w), .dev_addr(7'h2a), .nack_at(nack_at),
        .pull(pull));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] r,
        input logic [7:0] n);
        int k;
        nwr = 0;
        nrd = 0;
        repeat (4) @(posedge clk);
        {cmd_read, cmd_addr, cmd_reg, cmd_len} <= {rd, a, r, n};
        cmd_valid <= 1'b1;
        wr_data <= 8'h81;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (k = 0; k < 5000 && done !== 1'b1; k++) begin
            @(posedge clk);
            if (wr_ready === 1'b1) begin
                nwr++;
                wr_data <= 8'h81 + 8'(nwr);
            end
            if (rd_valid === 1'b1) begin
                got[nrd] = rd_data;
                nrd++;
            end
        end
        if (k == 5000) begin
            n_errors++;
            $display("[ERR] done wait expected 1 seen 0");
            test_done();
        end
    endtask
    task automatic t_reset();
        chk("busy", 8'h00, {7'h0, busy});
        chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
    endtask
    task automatic t_write();
        int k;
        run(1'b0, 7'h2a, 8'h10, 8'h03);
        chk("addr byte", 8'h54, dev.rx[0]);
        chk("reg byte", 8'h10, dev.rx[1]);
        for (k = 0; k < 3; k++) chk("data byte", 8'h81 + 8'(k), dev.rx[2 + k]);
        chk("byte count", 8'h05, 8'(dev.ri));
        chk("takes", 8'h03, 8'(nwr));
        chk("flags", 8'h02, {6'h0, addr_ack, nack_err});
    endtask
    task automatic t_read();
        run(1'b1, 7'h2a, 8'h20, 8'h02);
        chk("addr byte", 8'h54, dev.rx[0]);
        chk("reg byte", 8'h20, dev.rx[1]);
        chk("read addr", 8'h55, dev.rx[2]);
        chk("reads", 8'h02, 8'(nrd));
        chk("read byte", 8'hc3, got[0]);
        chk("read byte", 8'hc2, got[1]);
        chk("master acks", 8'h01, {6'h0, dev.mack_log[1:0]});
    endtask
    task automatic t_absent();
        run(1'b0, 7'h11, 8'h10, 8'h01);
        chk("flags", 8'h01, {6'h0, addr_ack, nack_err});
        chk("byte count", 8'h01, 8'(dev.ri));
    endtask
    task automatic t_zero_len();
        run(1'b0, 7'h2a, 8'h30, 8'h00);
        chk("reg byte", 8'h30, dev.rx[1]);
        chk("data byte", 8'h81, dev.rx[2]);
        chk("byte count", 8'h03, 8'(dev.ri));
        chk("takes", 8'h01, 8'(nwr));
    endtask
    task automatic t_data_nack();
        nack_at <= 8'h03;
        run(1'b0, 7'h2a, 8'h10, 8'h04);
        chk("flags", 8'h03, {6'h0, addr_ack, nack_err});
        chk("byte count", 8'h04, 8'(dev.ri));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_write();
        t_read();
        t_absent();
        t_zero_len();
        t_data_nack();
        test_done();
    end
endmodule // tb
bind i2c_bus_master i2c_bus_master_sva #(.PHASE_DIV(PHASE_DIV)) u_sva (.clk(clk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .wr_ready(wr_ready), .busy(busy), .done(done),
    .nack_err(nack_err), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire
